// file: hw/sfc_pkg.sv
package sfc_pkg;

    // ****************************************************************
    // Clock and analogue scaling
    // ****************************************************************
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CMD_W = 12;
    // Speed command and minimum-speed setting arrive as millivolt codes.
    localparam logic [CMD_W-1:0] SPD_ZERO_MV = 12'hbb8; // 3000 mV gives 0% drive.
    localparam logic [CMD_W-1:0] SPD_FULL_MV = 12'h3e8; // 1000 mV gives 100% drive.
    localparam logic [CMD_W-1:0] SPD_SPAN_MV = 12'h7d0; // 2000 mV between the two.
    localparam logic [CMD_W-1:0] REF_LEVEL_MV = 12'hbb8; // Reference output level.

    // ****************************************************************
    // PWM carrier timing
    // ****************************************************************
    localparam int unsigned PWM_FREQ_HZ = 24_000;
    localparam int unsigned PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
    // Ramp currents in tenths of a microamp set the rise to fall split.
    localparam int unsigned RAMP_CHARGE_DUA = 76;
    localparam int unsigned RAMP_DISCHARGE_DUA = 800;
    localparam int unsigned PER_W = 16;

    // ****************************************************************
    // Locked-rotor timing
    // ****************************************************************
    localparam int unsigned LOCK_DETECT_MS = 500;
    localparam int unsigned LOCK_OFF_MS = 3000;
    localparam int unsigned ON_OFF_RATIO = 12;
    localparam int unsigned LOCK_DETECT_CYC = (CLK_HZ / 1000) * LOCK_DETECT_MS;
    localparam int unsigned LOCK_OFF_CYC = (CLK_HZ / 1000) * LOCK_OFF_MS;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PWM_PERIOD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_INT_STAT = 8'h0c;
    localparam logic [7:0] REG_INT_MASK = 8'h10;
    localparam logic [7:0] REG_DUTY = 8'h14;
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam logic [0:0] CTRL_RESET = 1'h1;
    localparam logic [PER_W-1:0] PWM_PERIOD_RESET = 16'h1046; // 4166 cycles.
    localparam int unsigned INT_W = 3;
    localparam int unsigned INT_LOCK_BIT = 0;
    localparam int unsigned INT_RETRY_BIT = 1;
    localparam int unsigned INT_RESUME_BIT = 2;
    localparam logic [INT_W-1:0] INT_MASK_RESET = 3'h0;

    typedef enum logic [2:0] {
        SFC_RUN = 3'b001,
        SFC_LOCK_OFF = 3'b010,
        SFC_LOCK_ON = 3'b100
    } sfc_state_e;

endpackage

// file: hw/sfc_top.sv
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/100ps
// Functional notes
// - Hall positive above negative selects phase b, else phase a.
// - Command 3 V gives 0% duty, 1 V gives 100%, linear between.
// - Command above 3 V with minimum-speed setting at or above 3 V forces PWM drive fully off.
// - Command at ground gives full 100% drive.
// - Effective command is clamped not to exceed minimum-speed setting.
// - Minimum-speed setting at reference level applies no clamp.
// - PWM carrier period is configurable, nominal about 24 kHz.
// - Each PWM period is a rising ramp then a falling ramp.
// - After lock detection time without rotation, flag rises, drive stops.
// - While locked, alternate drive-off wait and retry-on drive until rotation.
// - Lock flag high while stopped, low while running, open-drain.
// - Tach output copies Hall signal, open-drain.
// - Active low-side output carries PWM, driven low in off interval.
// - Inactive phase low-side output held low.
// - High-side outputs carry commutation only, active-low pull-down.
// - Retry-on time to off-wait time ratio is one to twelve.
module sfc_top #(
    parameter int unsigned LOCK_DETECT_CYCLES = sfc_pkg::LOCK_DETECT_CYC,
    parameter int unsigned LOCK_OFF_CYCLES = sfc_pkg::LOCK_OFF_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_hall_pos_above,
    input wire logic [sfc_pkg::CMD_W-1:0] i_speed_cmd_in,
    input wire logic [sfc_pkg::CMD_W-1:0] i_min_speed_in,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_irq,
    output logic o_phase_a_low_drive,
    output logic o_phase_b_low_drive,
    output logic o_phase_a_high_drive,
    output logic o_phase_a_high_drive_oe,
    output logic o_phase_b_high_drive,
    output logic o_phase_b_high_drive_oe,
    output logic o_tach_out,
    output logic o_tach_out_oe,
    output logic o_lock_flag,
    output logic o_lock_flag_oe
);
    import sfc_pkg::*;

    localparam int unsigned RETRY_ON_CYCLES = LOCK_OFF_CYCLES / ON_OFF_RATIO;

    // Cycles of the falling ramp within one carrier period.
    function automatic logic [PER_W-1:0] fall_len(input logic [PER_W-1:0] per);
        logic [31:0] prod;
        prod = 32'(per) * 32'(RAMP_CHARGE_DUA) / 32'(RAMP_CHARGE_DUA + RAMP_DISCHARGE_DUA);
        return prod[PER_W-1:0];
    endfunction

    // ****************************************************************
    // Hall synchroniser and edge detection
    // ****************************************************************
    logic hall_meta_ff, hall_sync_ff, hall_prev_ff;
    logic nxt_hall_meta, nxt_hall_sync, nxt_hall_prev;
    logic hall_edge;

    // The first stage only feeds the second; edges use the clean copy.
    always_comb begin
        nxt_hall_meta = i_hall_pos_above;
        nxt_hall_sync = hall_meta_ff;
        nxt_hall_prev = hall_sync_ff;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hall_meta_ff <= 1'b0;
            hall_sync_ff <= 1'b0;
            hall_prev_ff <= 1'b0;
        end else begin
            hall_meta_ff <= nxt_hall_meta;
            hall_sync_ff <= nxt_hall_sync;
            hall_prev_ff <= nxt_hall_prev;
        end
    end

    assign hall_edge = hall_sync_ff ^ hall_prev_ff;

    // ****************************************************************
    // Speed command clamp and duty
    // ****************************************************************
    logic [CMD_W-1:0] eff_cmd;
    logic [PER_W-1:0] on_cycles;
    logic [PER_W-1:0] pwm_period_ff;
    logic [31:0] on_prod;

    // A higher voltage means lower speed, so the clamp sets a speed floor.
    always_comb begin
        eff_cmd = i_speed_cmd_in;
        if ((i_min_speed_in != REF_LEVEL_MV) && (i_speed_cmd_in > i_min_speed_in)) begin
            eff_cmd = i_min_speed_in;
        end
        on_prod = 32'h0;
        if (eff_cmd >= SPD_ZERO_MV) begin
            on_cycles = '0;
        end else if (eff_cmd <= SPD_FULL_MV) begin
            on_cycles = pwm_period_ff;
        end else begin
            on_prod = 32'(pwm_period_ff) * 32'(SPD_ZERO_MV - eff_cmd) / 32'(SPD_SPAN_MV);
            on_cycles = on_prod[PER_W-1:0];
        end
    end

    // ****************************************************************
    // PWM carrier: rising ramp then falling ramp
    // ****************************************************************
    logic [PER_W-1:0] pwm_cnt_ff, nxt_pwm_cnt;
    logic ramp_up;
    logic pwm_on;

    // Duty spans both ramps; full duty stays on while a shortened period wraps.
    always_comb begin
        if (pwm_cnt_ff >= pwm_period_ff - 16'h1) begin
            nxt_pwm_cnt = '0;
        end else begin
            nxt_pwm_cnt = pwm_cnt_ff + 16'h1;
        end
        ramp_up = pwm_cnt_ff < (pwm_period_ff - fall_len(pwm_period_ff));
        pwm_on = (on_cycles >= pwm_period_ff) || (pwm_cnt_ff < on_cycles);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwm_cnt_ff <= '0;
        end else begin
            pwm_cnt_ff <= nxt_pwm_cnt;
        end
    end

    // ****************************************************************
    // Locked-rotor supervisor
    // ****************************************************************
    sfc_state_e state_ff, nxt_state;
    logic [31:0] lock_cnt_ff, nxt_lock_cnt;
    logic ev_lock, ev_retry, ev_resume;

    // A Hall edge always wins, so a rotor that restarts mid-retry is caught.
    always_comb begin
        nxt_state = state_ff;
        nxt_lock_cnt = lock_cnt_ff + 32'h1;
        ev_lock = 1'b0;
        ev_retry = 1'b0;
        ev_resume = 1'b0;
        if (hall_edge) begin
            nxt_state = SFC_RUN;
            nxt_lock_cnt = '0;
            ev_resume = (state_ff != SFC_RUN);
        end else begin
            case (state_ff)
                SFC_RUN: begin
                    if (lock_cnt_ff >= LOCK_DETECT_CYCLES - 1) begin
                        nxt_state = SFC_LOCK_OFF;
                        nxt_lock_cnt = '0;
                        ev_lock = 1'b1;
                    end
                end
                SFC_LOCK_OFF: begin
                    if (lock_cnt_ff >= LOCK_OFF_CYCLES - 1) begin
                        nxt_state = SFC_LOCK_ON;
                        nxt_lock_cnt = '0;
                        ev_retry = 1'b1;
                    end
                end
                SFC_LOCK_ON: begin
                    if (lock_cnt_ff >= RETRY_ON_CYCLES - 1) begin
                        nxt_state = SFC_LOCK_OFF;
                        nxt_lock_cnt = '0;
                    end
                end
                default: begin
                    nxt_state = SFC_RUN;
                    nxt_lock_cnt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= SFC_RUN;
            lock_cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            lock_cnt_ff <= nxt_lock_cnt;
        end
    end

    // ****************************************************************
    // APB register file and interrupt
    // ****************************************************************
    logic ctrl_en_ff, nxt_ctrl_en;
    logic [PER_W-1:0] nxt_pwm_period;
    logic [INT_W-1:0] int_stat_ff, nxt_int_stat, int_mask_ff, nxt_int_mask;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr, irq_ff, nxt_irq;
    logic [INT_W-1:0] int_set;
    logic acc_done, hit;
    logic [31:0] rd_val;

    // One wait state lets read data come from a flop; writes land on
    // the edge where the master sees pready high.
    always_comb begin
        acc_done = i_psel && i_penable && pready_ff;
        nxt_pready = i_psel && i_penable && !pready_ff;
        hit = 1'b1;
        case (i_paddr)
            REG_CTRL: rd_val = {31'h0, ctrl_en_ff};
            REG_PWM_PERIOD: rd_val = {16'h0, pwm_period_ff};
            REG_STATUS: rd_val = {27'h0, state_ff, ramp_up, hall_sync_ff};
            REG_INT_STAT: rd_val = {29'h0, int_stat_ff};
            REG_INT_MASK: rd_val = {29'h0, int_mask_ff};
            REG_DUTY: rd_val = {16'h0, on_cycles};
            default: begin
                rd_val = 32'h0;
                hit = 1'b0;
            end
        endcase
        nxt_prdata = (nxt_pready && !i_pwrite) ? rd_val : prdata_ff;
        nxt_pslverr = nxt_pready && !hit;
        nxt_ctrl_en = ctrl_en_ff;
        nxt_pwm_period = pwm_period_ff;
        nxt_int_mask = int_mask_ff;
        nxt_int_stat = int_stat_ff;
        if (acc_done && i_pwrite) begin
            case (i_paddr)
                REG_CTRL: nxt_ctrl_en = i_pwdata[CTRL_EN_BIT];
                // A zero period would stall the carrier, so it is ignored.
                REG_PWM_PERIOD: nxt_pwm_period = (i_pwdata[PER_W-1:0] != '0) ?
                    i_pwdata[PER_W-1:0] : pwm_period_ff;
                REG_INT_MASK: nxt_int_mask = i_pwdata[INT_W-1:0];
                REG_INT_STAT: nxt_int_stat = int_stat_ff & ~i_pwdata[INT_W-1:0];
                default: nxt_ctrl_en = ctrl_en_ff;
            endcase
        end
        int_set = '0;
        int_set[INT_LOCK_BIT] = ev_lock;
        int_set[INT_RETRY_BIT] = ev_retry;
        int_set[INT_RESUME_BIT] = ev_resume;
        // A new event beats a clear arriving in the same cycle.
        nxt_int_stat = nxt_int_stat | int_set;
        nxt_irq = |(nxt_int_stat & nxt_int_mask);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_en_ff <= CTRL_RESET[0];
            pwm_period_ff <= PWM_PERIOD_RESET;
            int_stat_ff <= '0;
            int_mask_ff <= INT_MASK_RESET;
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            ctrl_en_ff <= nxt_ctrl_en;
            pwm_period_ff <= nxt_pwm_period;
            int_stat_ff <= nxt_int_stat;
            int_mask_ff <= nxt_int_mask;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            irq_ff <= nxt_irq;
        end
    end

    // ****************************************************************
    // Phase, tach and flag outputs
    // ****************************************************************
    logic drive_on, locked;
    logic a_lo_ff, b_lo_ff, a_hi_oe_ff, b_hi_oe_ff, tach_oe_ff, flag_oe_ff;
    logic nxt_a_lo, nxt_b_lo, nxt_a_hi_oe, nxt_b_hi_oe, nxt_tach_oe, nxt_flag_oe;

    // Open-drain pins drive zero; their enables carry the level.
    always_comb begin
        drive_on = ctrl_en_ff && (state_ff != SFC_LOCK_OFF);
        locked = (state_ff != SFC_RUN);
        nxt_a_hi_oe = drive_on && !hall_sync_ff;
        nxt_b_hi_oe = drive_on && hall_sync_ff;
        nxt_a_lo = drive_on && !hall_sync_ff && pwm_on;
        nxt_b_lo = drive_on && hall_sync_ff && pwm_on;
        nxt_tach_oe = !hall_sync_ff;
        nxt_flag_oe = !locked;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            a_lo_ff <= 1'b0;
            b_lo_ff <= 1'b0;
            a_hi_oe_ff <= 1'b0;
            b_hi_oe_ff <= 1'b0;
            tach_oe_ff <= 1'b1;
            flag_oe_ff <= 1'b1;
        end else begin
            a_lo_ff <= nxt_a_lo;
            b_lo_ff <= nxt_b_lo;
            a_hi_oe_ff <= nxt_a_hi_oe;
            b_hi_oe_ff <= nxt_b_hi_oe;
            tach_oe_ff <= nxt_tach_oe;
            flag_oe_ff <= nxt_flag_oe;
        end
    end

    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_irq = irq_ff;
    assign o_phase_a_low_drive = a_lo_ff;
    assign o_phase_b_low_drive = b_lo_ff;
    assign o_phase_a_high_drive = 1'b0;
    assign o_phase_a_high_drive_oe = a_hi_oe_ff;
    assign o_phase_b_high_drive = 1'b0;
    assign o_phase_b_high_drive_oe = b_hi_oe_ff;
    assign o_tach_out = 1'b0;
    assign o_tach_out_oe = tach_oe_ff;
    assign o_lock_flag = 1'b0;
    assign o_lock_flag_oe = flag_oe_ff;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    phase_select_a: assert property (
        ##1 o_phase_b_high_drive_oe == $past(drive_on && hall_sync_ff))
        else $error("high-side phase b does not follow hall selection");
    duty_off_a: assert property (
        (eff_cmd >= SPD_ZERO_MV) |=> !o_phase_a_low_drive && !o_phase_b_low_drive)
        else $error("low side driven with command at or above zero-drive level");
    full_drive_a: assert property (
        (eff_cmd <= SPD_FULL_MV) && drive_on && !hall_sync_ff |=> o_phase_a_low_drive)
        else $error("full command did not give full drive");
    min_clamp_a: assert property (
        (i_min_speed_in != REF_LEVEL_MV) |-> eff_cmd <= i_min_speed_in)
        else $error("effective command above minimum-speed setting");
    no_clamp_a: assert property (
        (i_min_speed_in == REF_LEVEL_MV) |-> eff_cmd == i_speed_cmd_in)
        else $error("clamp applied with setting at reference");
    ramp_order_a: assert property ((pwm_cnt_ff == '0) |-> ramp_up)
        else $error("period does not open with rising ramp");
    lock_entry_a: assert property ((state_ff == SFC_RUN) && !hall_edge
        && (lock_cnt_ff == LOCK_DETECT_CYCLES - 1) |=> (state_ff == SFC_LOCK_OFF) ##1
        (!o_lock_flag_oe && !o_phase_a_high_drive_oe && !o_phase_b_high_drive_oe))
        else $error("lock window expiry did not stop drive and raise flag");
    off_hold_a: assert property (
        (state_ff == SFC_LOCK_OFF) |=> !o_phase_a_low_drive && !o_phase_b_low_drive)
        else $error("drive present during off-wait");
    retry_len_a: assert property ((state_ff == SFC_LOCK_ON) && !hall_edge
        && (lock_cnt_ff == RETRY_ON_CYCLES - 1)
        |=> state_ff == SFC_LOCK_OFF)
        else $error("retry-on time length wrong");
    flag_pin_a: assert property (
        ##1 o_lock_flag_oe == !$past(locked))
        else $error("lock flag pin does not follow lock state");
    tach_copy_a: assert property (
        ##1 o_tach_out_oe == !$past(hall_sync_ff))
        else $error("tach pin does not follow hall");
    one_low_a: assert property (!(o_phase_a_low_drive && o_phase_b_low_drive))
        else $error("both low sides driven");
    edge_clear_a: assert property (
        hall_edge |=> (state_ff == SFC_RUN) && (lock_cnt_ff == '0))
        else $error("hall edge did not clear lock supervision");

    lock_seen_c: cover property ((state_ff == SFC_LOCK_OFF) ##1 (state_ff == SFC_LOCK_ON));
    resume_c: cover property ((state_ff == SFC_LOCK_ON) ##1 (state_ff == SFC_RUN));
    pwm_mid_c: cover property (o_phase_b_low_drive
        ##1 !o_phase_b_low_drive && o_phase_b_high_drive_oe);

endmodule // sfc_top

// file: sim/sfc_hall_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Hall sensor stand-in
// ****************************************************************
// Toggles the comparator level every half period while the rotor turns.
module sfc_hall_model (
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic [15:0] i_half_cyc,
    output logic o_hall
);
    logic [15:0] cnt_ff;
    initial begin
        cnt_ff = 16'h0;
        o_hall = 1'b0;
    end
    // A stalled rotor leaves the magnet where it stopped, so the level holds.
    always @(posedge i_clk) begin
        if (!i_run) begin
            cnt_ff <= 16'h0;
        end else if (cnt_ff >= i_half_cyc - 16'h1) begin
            cnt_ff <= 16'h0;
            o_hall <= ~o_hall;
        end else begin
            cnt_ff <= cnt_ff + 16'h1;
        end
    end
endmodule // sfc_hall_model

// file: sim/test_single_phase_fan_commutator.sv
`timescale 1ns/100ps
module test_single_phase_fan_commutator;
    import sfc_pkg::*;
    // ****************************************************************
    // Signals, design and rotor
    // ****************************************************************
    localparam int DET = 200;
    localparam int OFF = 240;
    logic i_clk = 1'b0, i_rst_n = 1'b0, run = 1'b1, hall;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, irq;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [11:0] speed_cmd_in = 12'h0, smin = 12'hbb8;
    logic al, bl, ahoe, bhoe, tachoe, flagoe, ahd, bhd, tach, flag;
    int err_count = 0, n_compared = 0, cyc = 0;
    logic [7:0] ra[4] = '{REG_CTRL, REG_PWM_PERIOD, REG_INT_MASK, 8'h40};
    logic [31:0] rv[4] = '{32'h1, 32'h1046, 32'h0, 32'h0};
    int cs[9] = '{0, 1000, 1001, 2000, 2999, 3000, 3001, 4095, 2800};
    int cm[9] = '{3000, 3000, 3000, 3000, 3000, 3000, 3000, 3000, 2000};
    sfc_top #(.LOCK_DETECT_CYCLES(DET), .LOCK_OFF_CYCLES(OFF)) dut (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_hall_pos_above(hall), .i_speed_cmd_in(speed_cmd_in),
        .i_min_speed_in(smin), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_irq(irq), .o_phase_a_low_drive(al),
        .o_phase_b_low_drive(bl), .o_phase_a_high_drive(ahd),
        .o_phase_a_high_drive_oe(ahoe), .o_phase_b_high_drive(bhd),
        .o_phase_b_high_drive_oe(bhoe), .o_tach_out(tach), .o_tach_out_oe(tachoe),
        .o_lock_flag(flag), .o_lock_flag_oe(flagoe));
    sfc_hall_model rotor (.i_clk(i_clk), .i_run(run), .i_half_cyc(16'h32), .o_hall(hall));
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    // A hung wait must not stall the run forever.
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // One bus transfer; pready, read data and error are taken at one rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic se);
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge i_clk);
        penable <= 1'b1;
        // Values read at the edge are those that stood before it; the loop has no cycle limit, so only the timeout ends a hung wait.
        do begin
            @(posedge i_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits for the drive (f=0) or the lock-flag enable (f=1) to reach a level.
    task automatic wt(input bit f, input logic lvl, output int n);
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while ((f ? flagoe : (al | bl)) !== lvl && n < 1000);
    endtask
    task automatic cnt(input int c, output int h);
        h = 0;
        repeat (c) begin
            @(negedge i_clk);
            h += int'(al | bl);
        end
    endtask
    function automatic int exp_on(int s, int m, int p);
        int e;
        e = (m != 3000 && m < s) ? m : s;
        if (e >= 3000) return 0;
        if (e <= 1000) return p;
        return p * (3000 - e) / 2000;
    endfunction
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        int n, h, s, m;
        logic [31:0] rd;
        logic se;
        void'($urandom(32'had2f2045));
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ra[i], 32'h0, rd, se);
            chk(rd, rv[i], "reset value");
            chk(32'(se), 32'(i == 3), "slave error");
        end
        chk({ahd, bhd, tach, flag}, 4'h0, "pull-down levels");
        apb(1'b1, REG_PWM_PERIOD, 32'h64, rd, se);
        apb(1'b1, REG_PWM_PERIOD, 32'h0, rd, se);
        apb(1'b0, REG_PWM_PERIOD, 32'h0, rd, se);
        chk(rd, 32'h64, "period");
        // Corner commands first, then random command and floor pairs.
        for (int i = 0; i < 14; i++) begin
            s = (i < 9) ? cs[i] : $urandom_range(4095, 0);
            m = (i < 9) ? cm[i] : $urandom_range(3000, 1000);
            @(posedge i_clk);
            speed_cmd_in <= 12'(s);
            smin <= 12'(m);
            repeat (300) @(posedge i_clk);
            apb(1'b0, REG_DUTY, 32'h0, rd, se);
            chk(rd, 32'(exp_on(s, m, 100)), "duty");
            cnt(100, h);
            chk(32'(h), 32'(exp_on(s, m, 100)), "on count");
        end
        @(posedge i_clk);
        speed_cmd_in <= 12'h0;
        smin <= 12'hbb8;
        for (int i = 0; i < 4; i++) begin
            @(hall);
            repeat (8) @(negedge i_clk);
            chk({al, bl}, hall ? 2'b01 : 2'b10, "low side");
            chk({ahoe, bhoe}, hall ? 2'b01 : 2'b10, "high side");
            chk(32'(tachoe), 32'(!hall), "tach");
        end
        apb(1'b1, REG_CTRL, 32'h0, rd, se);
        // The output flops need one more edge to see the new enable.
        @(posedge i_clk);
        cnt(100, h);
        chk(32'(h), 32'h0, "disabled");
        apb(1'b1, REG_CTRL, 32'h1, rd, se);
        // Stall the rotor right after an edge so the lock window is timed from it.
        @(hall);
        @(posedge i_clk);
        run <= 1'b0;
        wt(1'b1, 1'b0, n);
        chk(32'(n >= DET && n <= DET + 8), 32'h1, "lock time");
        chk({al, bl, ahoe, bhoe}, 4'h0, "lock off");
        wt(1'b0, 1'b1, n);
        chk(32'(n >= OFF - 2 && n <= OFF + 2), 32'h1, "off wait");
        wt(1'b0, 1'b0, n);
        chk(32'(n >= OFF / 12 - 2 && n <= OFF / 12 + 2), 32'h1, "retry on");
        chk(32'(flagoe), 32'h0, "flag in retry");
        apb(1'b0, REG_INT_STAT, 32'h0, rd, se);
        chk(rd, 32'h3, "lock events");
        chk(32'(irq), 32'h0, "masked irq");
        apb(1'b0, REG_STATUS, 32'h0, rd, se);
        chk(rd & 32'h1d, {27'h0, 3'b010, 1'b0, hall}, "status");
        apb(1'b1, REG_INT_MASK, 32'h7, rd, se);
        @(negedge i_clk);
        chk(32'(irq), 32'h1, "irq raised");
        @(posedge i_clk);
        run <= 1'b1;
        wt(1'b1, 1'b1, n);
        chk(32'(n <= 60), 32'h1, "resume");
        apb(1'b0, REG_INT_STAT, 32'h0, rd, se);
        chk(rd, 32'h7, "resume event");
        apb(1'b1, REG_INT_STAT, 32'h7, rd, se);
        apb(1'b0, REG_INT_STAT, 32'h0, rd, se);
        chk(rd, 32'h0, "cleared");
        @(negedge i_clk);
        chk(32'(irq), 32'h0, "irq cleared");
        results();
    end
endmodule // test_single_phase_fan_commutator
